// ===== core/vbcs_scheduler.sv
// Channel receive/transmit scheduler with shared retry, rearbitrate and abort.
`timescale 1ns/100ps
module vbcs_scheduler #(
  parameter int NCH = vbcs_pkg::NCH_DEF
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_chan_wr,
  input wire logic [vbcs_pkg::CHAN_W-1:0] i_chan_idx,
  input wire vbcs_pkg::vbcs_chan_wr_t i_chan_cfg,
  output logic [NCH-1:0] o_chan_tx_flag,
  output logic [NCH-1:0] o_chan_rx_flag,
  input wire logic i_rx_frame,
  input wire logic [NCH-1:0] i_rx_match,
  output logic o_rx_deliver,
  output logic [vbcs_pkg::CHAN_W-1:0] o_rx_chan,
  output logic o_tx_start,
  output logic [vbcs_pkg::CHAN_W-1:0] o_tx_chan,
  input wire logic i_tx_done,
  input wire vbcs_pkg::vbcs_tx_res_t i_tx_res,
  output logic o_idle,
  output logic o_te_flag
);

  localparam int CW = vbcs_pkg::CHAN_W;
  localparam int MW = vbcs_pkg::MR_W;

  generate
    if (NCH < 1 || NCH > (1 << CW)) begin : g_bad_nch
      $error("vbcs_scheduler: NCH out of range");
    end
  endgenerate

  function automatic logic [NCH-1:0] onehot(input logic [CW-1:0] idx);
    onehot = '0;
    onehot[idx] = 1'b1;
  endfunction

  // Channel flags.
  logic [NCH-1:0] producer_q;
  logic [NCH-1:0] channel_transmitted_flag_q;
  logic [NCH-1:0] channel_received_flag_q;
  logic [NCH-1:0] abort_pend_q;
  logic [NCH-1:0] channel_transmitted_flag_d;
  logic [NCH-1:0] channel_received_flag_d;
  logic [NCH-1:0] abort_pend_d;

  // Registers.
  logic [7:0] tx_ctrl_q;
  logic [2:0] last_err_q;
  logic [2:0] last_err_d;
  logic te_q;
  logic te_d;
  logic idle_req_q;
  logic idle_q;
  logic idle_d;
  logic rearb_q;
  logic rearb_d;
  logic rearb_seen_q;
  logic rearb_seen_d;
  logic [7:0] rdata_q;

  // Transmit scheduling state.
  vbcs_pkg::vbcs_state_t state_q;
  vbcs_pkg::vbcs_state_t state_d;
  logic [CW-1:0] cur_q;
  logic [CW-1:0] cur_d;
  logic locked_q;
  logic locked_d;
  logic [CW-1:0] resume_q;
  logic [CW-1:0] resume_d;
  logic resume_v_q;
  logic resume_v_d;
  logic [MW-1:0] retry_cnt_q;
  logic [MW-1:0] retry_cnt_d;
  logic [MW-1:0] retries_done_q;
  logic [MW-1:0] retries_done_d;

  // Register decode.
  wire wr_tx_ctrl = i_reg_wr && (i_reg_addr == vbcs_pkg::ADDR_TX_CTRL);
  wire wr_cmd = i_reg_wr && (i_reg_addr == vbcs_pkg::ADDR_CMD);
  wire wr_irq = i_reg_wr && (i_reg_addr == vbcs_pkg::ADDR_IRQ_STAT);
  wire [MW-1:0] max_retry_count = tx_ctrl_q[vbcs_pkg::MR_LSB +: MW];
  wire cmd_acti = i_reg_wdata[vbcs_pkg::CMD_ACTI_BIT];
  wire cmd_idle = i_reg_wdata[vbcs_pkg::CMD_IDLE_BIT];
  wire cmd_rearb = i_reg_wdata[vbcs_pkg::CMD_REARB_BIT];

  // Only produced channels join transmit scheduling.
  wire [NCH-1:0] tx_pending = producer_q & ~channel_transmitted_flag_q & ~abort_pend_q;
  // A channel that has received is no longer a candidate.
  wire [NCH-1:0] rx_active = ~channel_received_flag_q;
  wire [NCH-1:0] rx_cand = i_rx_match & rx_active;

  wire rx_any;
  wire [CW-1:0] rx_idx;
  wire tx_any;
  wire [CW-1:0] tx_idx;

  // Lowest matching active channel takes the frame.
  vbcs_prio_enc #(.N(NCH), .W(CW)) u_rx_prio (
    .i_req(rx_cand),
    .o_any(rx_any),
    .o_idx(rx_idx)
  );

  // Lowest pending channel number is served first.
  vbcs_prio_enc #(.N(NCH), .W(CW)) u_tx_prio (
    .i_req(tx_pending),
    .o_any(tx_any),
    .o_idx(tx_idx)
  );

  wire rx_take = i_rx_frame && rx_any;
  wire chan_wr_ok = i_chan_wr && (int'(i_chan_idx) < NCH);
  wire [NCH-1:0] wr_sel = chan_wr_ok ? onehot(i_chan_idx) : '0;
  wire [NCH-1:0] cur_sel = onehot(cur_q);
  wire in_attempt = (state_q != vbcs_pkg::VBCS_IDLE);
  // Abort is honoured only on an enabled producer channel.
  // It is ignored once the channel is already transmitted.
  wire abort_req = chan_wr_ok && i_chan_cfg.channel_abort_error_bit && producer_q[i_chan_idx]
                   && !channel_transmitted_flag_q[i_chan_idx];
  wire abort_defer = abort_req && in_attempt && (i_chan_idx == cur_q);
  wire [NCH-1:0] abort_now = (abort_req && !abort_defer) ? wr_sel : '0;
  wire [NCH-1:0] abort_late = abort_defer ? wr_sel : '0;

  // Attempt outcome decode.
  wire att_end = (state_q == vbcs_pkg::VBCS_WAIT) && i_tx_done;
  wire att_fail = !i_tx_res.ok && !i_tx_res.lost
                  && (i_tx_res.cv || i_tx_res.acknowledge_fault_flag || i_tx_res.frame_check_fault_flag);
  wire cur_aborted = abort_pend_q[cur_q];
  wire cur_disabled = channel_transmitted_flag_q[cur_q] || !producer_q[cur_q];
  wire exhausted = att_fail && (retry_cnt_q == '0);
  wire finished = att_end && (i_tx_res.ok || exhausted || cur_aborted || cur_disabled);
  // Idle waits while a rearbitrated sequence still has work.
  wire tx_work = in_attempt || locked_q || resume_v_q || (|tx_pending);
  // Entering idle blocks a start in the same cycle, so no attempt opens in idle.
  wire idle_enter = idle_req_q && !(rearb_seen_q && tx_work) && !in_attempt;
  wire can_start = !idle_q && !idle_enter && (locked_q ? tx_pending[cur_q] : tx_any);

  // Channel flag next values; hardware sets win over software clears.
  always_comb begin
    channel_transmitted_flag_d = (channel_transmitted_flag_q & ~wr_sel) | (wr_sel & {NCH{i_chan_cfg.channel_transmitted_flag}});
    channel_received_flag_d = (channel_received_flag_q & ~wr_sel) | (wr_sel & {NCH{i_chan_cfg.channel_received_flag}});
    abort_pend_d = (abort_pend_q & ~wr_sel) | abort_late;
    // A carried-out abort marks the channel transmitted.
    channel_transmitted_flag_d = channel_transmitted_flag_d | abort_now;
    if (att_end && (i_tx_res.ok || exhausted || cur_aborted)) begin
      // Transmitted flag set on success, exhaustion or a deferred abort.
      channel_transmitted_flag_d = channel_transmitted_flag_d | cur_sel;
      abort_pend_d = abort_pend_d & ~cur_sel;
    end
    if (rx_take) begin
      channel_received_flag_d = channel_received_flag_d | onehot(rx_idx);
    end
  end

  // Transmit sequencing with the single shared retry counter.
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    locked_d = locked_q;
    resume_d = resume_q;
    resume_v_d = resume_v_q;
    retry_cnt_d = retry_cnt_q;
    retries_done_d = retries_done_q;
    last_err_d = last_err_q;
    te_d = te_q;
    rearb_d = rearb_q || (wr_cmd && cmd_rearb);
    rearb_seen_d = rearb_seen_q || (wr_cmd && cmd_rearb);
    // Enabling a channel while nothing runs loads the counter.
    if (chan_wr_ok && !i_chan_cfg.channel_transmitted_flag && !locked_q && !in_attempt) begin
      retry_cnt_d = max_retry_count;
    end
    case (state_q)
      vbcs_pkg::VBCS_IDLE: begin
        if (can_start) begin
          if (!locked_q) begin
            // Every new channel starts from the one counter.
            cur_d = tx_idx;
            retry_cnt_d = max_retry_count;
            retries_done_d = '0;
          end
          locked_d = 1'b1;
          state_d = vbcs_pkg::VBCS_START;
        end else if (locked_q && !tx_pending[cur_q]) begin
          // A resumed channel that ended meanwhile must not hold the scheduler.
          locked_d = 1'b0;
        end
      end
      vbcs_pkg::VBCS_START: begin
        state_d = vbcs_pkg::VBCS_WAIT;
      end
      vbcs_pkg::VBCS_WAIT: begin
        if (i_tx_done) begin
          state_d = vbcs_pkg::VBCS_IDLE;
          if (att_fail) begin
            last_err_d[vbcs_pkg::ERR_CV_BIT] = i_tx_res.cv;
            last_err_d[vbcs_pkg::ERR_ACKNOWLEDGE_FAULT_FLAG_BIT] = i_tx_res.acknowledge_fault_flag;
            last_err_d[vbcs_pkg::ERR_FRAME_CHECK_FAULT_FLAG_BIT] = i_tx_res.frame_check_fault_flag;
          end
          // Lost contention leaves the counter alone.
          // Counter N allows N retries after the first attempt.
          if (att_fail && !exhausted && !cur_aborted) begin
            retry_cnt_d = retry_cnt_q - MW'(1);
            retries_done_d = retries_done_q + MW'(1);
          end
          // Failure with an empty counter raises the error flag.
          if (exhausted && !cur_aborted) begin
            te_d = 1'b1;
          end
          if (finished) begin
            // A disabled or ended channel gets no more attempts.
            locked_d = 1'b0;
            // A rearbitrate aimed at the ended loop has nothing left to postpone.
            rearb_d = wr_cmd && cmd_rearb;
            if (resume_v_q) begin
              // Reload and return to the pre-empted channel.
              cur_d = resume_q;
              locked_d = 1'b1;
              resume_v_d = 1'b0;
              retry_cnt_d = max_retry_count;
              retries_done_d = '0;
            end
          end else if (rearb_q) begin
            // Attempt done; reload and let priority decide again.
            resume_d = cur_q;
            resume_v_d = 1'b1;
            locked_d = 1'b0;
            rearb_d = 1'b0;
            retry_cnt_d = max_retry_count;
            retries_done_d = '0;
          end
        end
      end
      default: begin
        state_d = vbcs_pkg::VBCS_IDLE;
      end
    endcase
    if (wr_irq && i_reg_wdata[vbcs_pkg::IRQ_TE_BIT] && !(exhausted && !cur_aborted && att_end)) begin
      te_d = 1'b0;
    end
  end

  always_comb begin
    idle_d = idle_q;
    if (idle_enter) begin
      idle_d = 1'b1;
    end
    if (wr_cmd && cmd_acti && !cmd_idle) begin
      idle_d = 1'b0;
    end
  end

  // Read mux; unmapped offsets return zero.
  wire [7:0] tx_stat = {retries_done_q, cur_q};
  wire [7:0] rd_mux =
    (i_reg_addr == vbcs_pkg::ADDR_TX_CTRL) ? tx_ctrl_q :
    (i_reg_addr == vbcs_pkg::ADDR_CMD) ?
      8'({rearb_q, idle_req_q, 1'b0}) :
    // Retries performed and current channel number.
    (i_reg_addr == vbcs_pkg::ADDR_TX_STAT) ? tx_stat :
    (i_reg_addr == vbcs_pkg::ADDR_LAST_ERR) ? 8'(last_err_q) :
    (i_reg_addr == vbcs_pkg::ADDR_IRQ_STAT) ? 8'(te_q) : 8'h00;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      producer_q <= '0;
      channel_transmitted_flag_q <= '1;
      channel_received_flag_q <= '1;
      abort_pend_q <= '0;
    end else begin
      producer_q <= (producer_q & ~wr_sel) | (wr_sel & {NCH{i_chan_cfg.producer}});
      channel_transmitted_flag_q <= channel_transmitted_flag_d;
      channel_received_flag_q <= channel_received_flag_d;
      abort_pend_q <= abort_pend_d;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= vbcs_pkg::VBCS_IDLE;
      cur_q <= '0;
      locked_q <= 1'b0;
      resume_q <= '0;
      resume_v_q <= 1'b0;
      retry_cnt_q <= '0;
      retries_done_q <= '0;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      locked_q <= locked_d;
      resume_q <= resume_d;
      resume_v_q <= resume_v_d;
      retry_cnt_q <= retry_cnt_d;
      retries_done_q <= retries_done_d;
    end
  end

  // The device leaves reset in idle, as the line stays quiet until activated.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_ctrl_q <= vbcs_pkg::TX_CTRL_RST;
      last_err_q <= '0;
      te_q <= 1'b0;
      idle_req_q <= 1'b1;
      idle_q <= 1'b1;
      rearb_q <= 1'b0;
      rearb_seen_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      if (wr_tx_ctrl) begin
        tx_ctrl_q <= i_reg_wdata;
      end
      if (wr_cmd) begin
        idle_req_q <= cmd_idle;
      end
      last_err_q <= last_err_d;
      te_q <= te_d;
      idle_q <= idle_d;
      rearb_q <= rearb_d;
      rearb_seen_q <= (idle_d && !idle_q) ? 1'b0 : rearb_seen_d;
      if (i_reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Delivery strobe is registered so the channel number and pulse align.
  logic rx_deliver_q;
  logic [CW-1:0] rx_chan_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_deliver_q <= 1'b0;
      rx_chan_q <= '0;
    end else begin
      rx_deliver_q <= rx_take;
      if (rx_take) begin
        rx_chan_q <= rx_idx;
      end
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_chan_tx_flag = channel_transmitted_flag_q;
  assign o_chan_rx_flag = channel_received_flag_q;
  assign o_rx_deliver = rx_deliver_q;
  assign o_rx_chan = rx_chan_q;
  assign o_tx_start = (state_q == vbcs_pkg::VBCS_START);
  assign o_tx_chan = cur_q;
  assign o_idle = idle_q;
  assign o_te_flag = te_q;

endmodule

// ===== shared/vbcs_pkg.sv
// Constants, types and field layout shared by the channel scheduler files.
package vbcs_pkg;

  localparam int CHAN_W = 4;
  localparam int NCH_DEF = 14;

  localparam logic [7:0] ADDR_TX_CTRL = 8'h01;
  localparam logic [7:0] ADDR_CMD = 8'h03;
  localparam logic [7:0] ADDR_TX_STAT = 8'h05;
  localparam logic [7:0] ADDR_LAST_ERR = 8'h07;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h09;

  localparam logic [7:0] TX_CTRL_RST = 8'h00;
  localparam int MR_LSB = 0;
  localparam int MR_W = 4;

  localparam int CMD_ACTI_BIT = 0;
  localparam int CMD_IDLE_BIT = 1;
  localparam int CMD_REARB_BIT = 2;

  localparam int STAT_CHAN_LSB = 0;
  localparam int STAT_RETRY_LSB = 4;

  localparam int ERR_CV_BIT = 0;
  localparam int ERR_ACKNOWLEDGE_FAULT_FLAG_BIT = 1;
  localparam int ERR_FRAME_CHECK_FAULT_FLAG_BIT = 2;

  localparam int IRQ_TE_BIT = 0;

  // Software write to one channel's producer, status and abort bits.
  typedef struct packed {
    logic producer;
    logic channel_transmitted_flag;
    logic channel_received_flag;
    logic channel_abort_error_bit;
  } vbcs_chan_wr_t;

  // Outcome of one bus attempt, reported by the line engine.
  typedef struct packed {
    logic ok;
    logic lost;
    logic cv;
    logic acknowledge_fault_flag;
    logic frame_check_fault_flag;
  } vbcs_tx_res_t;

  typedef enum logic [1:0] {
    VBCS_IDLE  = 2'b00,
    VBCS_START = 2'b01,
    VBCS_WAIT  = 2'b11
  } vbcs_state_t;

endpackage

// ===== core/vbcs_prio_enc.sv
// Lowest-index-first priority encoder over a request vector.
`timescale 1ns/100ps
module vbcs_prio_enc #(
  parameter int N = 14,
  parameter int W = 4
) (
  input wire logic [N-1:0] i_req,
  output logic o_any,
  output logic [W-1:0] o_idx
);

  generate
    if (N > (1 << W)) begin : g_bad
      $error("vbcs_prio_enc: N does not fit in W bits");
    end
  endgenerate

  // Scanning from the top down leaves the lowest set index in place.
  always_comb begin
    o_idx = '0;
    for (int k = N - 1; k >= 0; k--) begin
      if (i_req[k]) begin
        o_idx = W'(k);
      end
    end
  end

  assign o_any = |i_req;

endmodule

// ===== sim/vbcs_sched_properties.sv
// Port-level assertions for the channel scheduler.
`timescale 1ns/100ps
module vbcs_sched_properties #(
  parameter int NCH = 14
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_rx_frame,
  input wire logic [NCH-1:0] i_rx_match,
  input wire logic [NCH-1:0] o_chan_rx_flag,
  input wire logic [NCH-1:0] o_chan_tx_flag,
  input wire logic o_rx_deliver,
  input wire logic [3:0] o_rx_chan,
  input wire logic o_tx_start,
  input wire logic [3:0] o_tx_chan,
  input wire logic i_tx_done,
  input wire vbcs_pkg::vbcs_tx_res_t i_tx_res,
  input wire logic o_idle,
  input wire logic o_te_flag
);
  logic busy_q;
  logic fail;
  logic [NCH-1:0] live;
  logic [3:0] low;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  assign live = i_rx_match & ~o_chan_rx_flag;
  assign fail = busy_q & i_tx_done & ~i_tx_res.ok & ~i_tx_res.lost;
  always_comb begin
    low = 4'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (live[i]) low = i[3:0];
    end
  end
  // Done pulses outside an attempt are ignored by the design, so track the window.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) busy_q <= 1'b0;
    else if (o_tx_start) busy_q <= 1'b1;
    else if (i_tx_done) busy_q <= 1'b0;
  end
  sequence frame_hit;
    i_rx_frame && (|live);
  endsequence
  sequence frame_taken;
    frame_hit ##1 o_rx_deliver;
  endsequence
  rx_deliver_a: assert property (frame_hit |=> o_rx_deliver)
    else $error("active match not delivered");
  rx_lowest_a: assert property (frame_taken |-> o_rx_chan == $past(low))
    else $error("frame went to a higher channel");
  rx_retire_a: assert property (o_rx_deliver |-> o_chan_rx_flag[o_rx_chan])
    else $error("receiving channel still active");
  rx_refuse_a: assert property (!(i_rx_frame && (|live)) |=> !o_rx_deliver)
    else $error("delivery without active match");
  tx_pending_a: assert property (o_tx_start |-> !o_chan_tx_flag[o_tx_chan])
    else $error("attempt on a transmitted channel");
  one_attempt_a: assert property (busy_q && !i_tx_done |-> !o_tx_start)
    else $error("second attempt while one is open");
  te_cause_a: assert property ($rose(o_te_flag) |-> $past(fail) || $past(fail, 2))
    else $error("error flag without a failed attempt");
  idle_quiet_a: assert property (o_idle |-> !o_tx_start)
    else $error("attempt started in idle");
endmodule

// ===== sim/vbcs_bus_node.sv
// Behavioural model of the other bus nodes answering each attempt.
`timescale 1ns/100ps
module vbcs_bus_node (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [3:0] i_wait,
  input wire vbcs_pkg::vbcs_tx_res_t i_res,
  output logic o_done,
  output vbcs_pkg::vbcs_tx_res_t o_res
);
  int cnt;
  // Outside the done pulse the result lines show the inverse, so a stale value cannot match.
  assign o_res = o_done ? i_res : ~i_res;
  always @(negedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt = 0;
      o_done <= 1'b0;
    end else if (i_start) begin
      cnt = i_wait;
      o_done <= 1'b0;
    end else begin
      o_done <= (cnt == 1);
      if (cnt > 0) cnt = cnt - 1;
    end
  end
endmodule

// ===== sim/test_vehicle_bus_channel_tx_scheduler.sv
// Self-checking bench for the channel scheduler.
`timescale 1ns/100ps
module test_vehicle_bus_channel_tx_scheduler;
  localparam int NCH = 14;
  localparam vbcs_pkg::vbcs_tx_res_t OK = 5'h10, LOST = 5'h08, CV = 5'h04;
  localparam vbcs_pkg::vbcs_tx_res_t ACK = 5'h02, FCS = 5'h01;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, cwr = 1'b0, frm = 1'b0;
  logic dlv, start, done, idle, te, got;
  logic [3:0] cidx = 4'h0, wt = 4'h6, rch, tch, lo;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  logic [NCH-1:0] txf, rxf, m, hit, mrx, match = 14'h0000;
  logic [31:0] seed = 32'h00017eb2, r;
  vbcs_pkg::vbcs_chan_wr_t cfg = 4'h0;
  vbcs_pkg::vbcs_tx_res_t res = 5'h10, bres;
  vbcs_pkg::vbcs_tx_res_t rq[$];
  int miscompares = 0, tests_run = 0, cyc = 0, eq[$];
  vbcs_scheduler #(.NCH(NCH)) i_dut (.i_clk(clk), .i_rstn(rstn), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_chan_wr(cwr),
    .i_chan_idx(cidx), .i_chan_cfg(cfg), .o_chan_tx_flag(txf), .o_chan_rx_flag(rxf),
    .i_rx_frame(frm), .i_rx_match(match), .o_rx_deliver(dlv), .o_rx_chan(rch),
    .o_tx_start(start), .o_tx_chan(tch), .i_tx_done(done), .i_tx_res(bres), .o_idle(idle),
    .o_te_flag(te));
  vbcs_bus_node i_node (.i_clk(clk), .i_rstn(rstn), .i_start(start), .i_wait(wt),
    .i_res(res), .o_done(done), .o_res(bres));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk) wr = 1'b0;
  endtask
  task automatic rreg(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) addr = a;
    rd = 1'b1;
    @(negedge clk) rd = 1'b0;
    @(negedge clk) chk(nm, e, rdata);
  endtask
  task automatic cw(input logic [3:0] idx, input logic [3:0] c);
    @(negedge clk) cidx = idx;
    cfg = c;
    cwr = 1'b1;
    @(negedge clk) cwr = 1'b0;
  endtask
  task automatic wsig(input bit want_done);
    for (int n = 0; n < 400 && !(want_done ? done : start); n++) @(negedge clk);
  endtask
  // Waits for the last queued attempt to end; leftovers mean too few attempts.
  task automatic run();
    for (int n = 0; n < 900 && (eq.size() != 0 || !done); n++) @(negedge clk);
    repeat (3) @(negedge clk);
    chk("queue", 8'h00, 8'(eq.size()));
  endtask
  // Each attempt is checked against the expected channel and answered from the queue.
  always @(negedge clk) begin
    if (start && eq.size() == 0) chk("tx_chan", 8'hff, {4'h0, tch});
    else if (start) begin
      chk("tx_chan", 8'(eq.pop_front()), {4'h0, tch});
      res <= rq.pop_front();
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    mrx = {NCH{1'b1}};
    @(negedge clk) chk("tx_flags", 8'hff, txf[7:0]);
    chk("idle", 8'h01, {7'h0, idle});
    rreg("unmapped", 8'h0e, 8'h00);
    wreg(8'h01, 8'ha1);
    rreg("tx_ctrl", 8'h01, 8'ha1);
    cw(4'h9, 4'ha);
    cw(4'h2, 4'ha);
    eq = '{2, 9};
    rq = '{OK, OK};
    wreg(8'h03, 8'h01);
    run();
    chk("idle", 8'h00, {7'h0, idle});
    eq = '{8, 8};
    rq = '{ACK, CV};
    cw(4'h8, 4'ha);
    wsig(1'b1);
    rreg("tx_status", 8'h05, 8'h18);
    run();
    chk("te", 8'h01, {7'h0, te});
    chk("tx_flag8", 8'h01, {7'h0, txf[8]});
    rreg("last_err", 8'h07, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wreg(8'h09, 8'h01);
      chk("te_clear", 8'h00, {7'h0, te});
      r = rnd();
      wt = 4'h3 + {2'h0, r[5:4]};
      wreg(8'h01, {6'h00, r[1:0]});
      repeat (r[3:2]) eq.push_back(10 + k);
      repeat (r[3:2]) rq.push_back(LOST);
      repeat (r[1:0] + 1) eq.push_back(10 + k);
      repeat (r[1:0] + 1) rq.push_back(FCS);
      cw(4'(10 + k), 4'ha);
      run();
      chk("te", 8'h01, {7'h0, te});
      rreg("last_err", 8'h07, 8'h04);
    end
    wreg(8'h09, 8'h01);
    wreg(8'h01, 8'h01);
    wt = 4'h8;
    eq = '{8, 5, 8, 8};
    rq = '{FCS, OK, FCS, FCS};
    cw(4'h8, 4'ha);
    wsig(1'b0);
    cw(4'h5, 4'ha);
    wreg(8'h03, 8'h05);
    wreg(8'h03, 8'h02);
    chk("idle", 8'h00, {7'h0, idle});
    run();
    chk("idle", 8'h01, {7'h0, idle});
    chk("te", 8'h01, {7'h0, te});
    wreg(8'h09, 8'h01);
    wreg(8'h03, 8'h01);
    wreg(8'h01, 8'h03);
    eq = '{6};
    rq = '{ACK};
    cw(4'h6, 4'ha);
    wsig(1'b0);
    cw(4'h6, 4'hb);
    run();
    chk("tx_flag6", 8'h01, {7'h0, txf[6]});
    chk("te", 8'h00, {7'h0, te});
    wreg(8'h01, 8'h01);
    eq = '{8, 5};
    rq = '{FCS, OK};
    cw(4'h8, 4'ha);
    wsig(1'b0);
    cw(4'h5, 4'ha);
    wreg(8'h03, 8'h05);
    cw(4'h8, 4'he);
    run();
    rreg("cmd", 8'h03, 8'h00);
    chk("te", 8'h00, {7'h0, te});
    // Non-producer channels with the flag clear must never be sent.
    for (int i = 0; i < NCH; i++) cw(i[3:0], 4'h0);
    cw(4'h3, 4'h1);
    chk("abort_refused", 8'h00, {7'h0, txf[3]});
    mrx = {NCH{1'b0}};
    for (int k = 0; k < 40; k++) begin
      r = rnd();
      m = r[NCH-1:0];
      hit = m & ~mrx;
      lo = 4'h0;
      for (int j = NCH - 1; j >= 0; j--) if (hit[j]) lo = j[3:0];
      @(negedge clk) match = m;
      frm = 1'b1;
      @(negedge clk) frm = 1'b0;
      match = ~m;
      got = dlv;
      @(negedge clk) got = got | dlv;
      chk("rx_deliver", {7'h0, |hit}, {7'h0, got});
      if (|hit) chk("rx_chan", {4'h0, lo}, {4'h0, rch});
      if (|hit) mrx[lo] = 1'b1;
    end
    chk("rx_flags_lo", mrx[7:0], rxf[7:0]);
    chk("rx_flags_hi", {2'h0, mrx[13:8]}, {2'h0, rxf[13:8]});
    give_verdict();
  end
endmodule
bind vbcs_scheduler vbcs_sched_properties #(.NCH(NCH)) i_props (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_rx_frame(i_rx_frame), .i_rx_match(i_rx_match),
  .o_chan_rx_flag(o_chan_rx_flag), .o_chan_tx_flag(o_chan_tx_flag),
  .o_rx_deliver(o_rx_deliver), .o_rx_chan(o_rx_chan), .o_tx_start(o_tx_start),
  .o_tx_chan(o_tx_chan), .i_tx_done(i_tx_done), .i_tx_res(i_tx_res), .o_idle(o_idle),
  .o_te_flag(o_te_flag));
